/* hw/psd_pkg.sv */
// Package with state codes, flag layout, carriers and timing for the positioning block
package psd_pkg;

  localparam int unsigned TICK_US       = 250;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned TICK_CYC_DEF  = TICK_US * CLK_MHZ;
  localparam int unsigned US_PER_MS     = 1000;
  localparam logic [2:0]  TICKS_PER_MS  = 3'(US_PER_MS / TICK_US);

  localparam int unsigned POS_W  = 32;
  localparam int unsigned TMO_W  = 19;
  localparam int unsigned FLAG_N = 6;

  // Flag positions follow diag sub-index minus one
  localparam int unsigned FB_REJECT  = 0;
  localparam int unsigned FB_ABORT   = 1;
  localparam int unsigned FB_OVERRUN = 2;
  localparam int unsigned FB_TIMEOUT = 3;
  localparam int unsigned FB_LAG     = 4;
  localparam int unsigned FB_EHALT   = 5;
  localparam logic [FLAG_N-1:0] FLAGS_RST = 6'h00;

  localparam logic [15:0] SC_INIT = 16'h0000, SC_IDLE = 16'h0001, SC_EVAL = 16'h0010;
  localparam logic [15:0] SC_UP   = 16'h0011, SC_CRUISE = 16'h0012, SC_DOWN = 16'h0013;
  localparam logic [15:0] SC_EMERGENCY_HALT_STATE = 16'h0040, SC_STOP = 16'h0041;
  localparam logic [15:0] SC_HB   = 16'h0100, SC_HSS = 16'h0110, SC_HOS = 16'h0111;
  localparam logic [15:0] SC_HSI  = 16'h0120, SC_HES = 16'h0121, SC_HD = 16'h0130;
  localparam logic [15:0] SC_CAL  = 16'h0140, SC_NOCAL = 16'h0141;
  localparam logic [15:0] SC_PRE  = 16'h1000, SC_TGT = 16'h1001, SC_RESTART = 16'h1002;
  localparam logic [15:0] SC_END  = 16'h2000, SC_WARN = 16'h4000, SC_ERR = 16'h8000;
  localparam logic [15:0] SC_UNDEF = 16'hFFFF;

  typedef enum logic [4:0] {
    ST_INIT    = 5'h00, ST_IDLE  = 5'h01, ST_EVAL = 5'h03, ST_UP    = 5'h02,
    ST_CRUISE  = 5'h06, ST_DOWN  = 5'h07, ST_PRE  = 5'h05, ST_TGT   = 5'h04,
    ST_END     = 5'h0C, ST_RESTART = 5'h0D, ST_WARN = 5'h0F, ST_ERR = 5'h0E,
    ST_EMERGENCY_HALT_STATE    = 5'h0A, ST_STOP  = 5'h0B, ST_HB   = 5'h09, ST_HSS   = 5'h08,
    ST_HOS     = 5'h18, ST_HSI   = 5'h19, ST_HES  = 5'h1B, ST_HD    = 5'h1A,
    ST_CAL     = 5'h1E, ST_NOCAL = 5'h1F, ST_UNDEF = 5'h1D
  } psd_state_e;

  typedef enum logic [1:0] {
    CMD_TRAVEL = 2'h0, CMD_HOME = 2'h1, CMD_HOME_IDX = 2'h2, CMD_UNCAL = 2'h3
  } psd_cmd_e;

  typedef struct packed {
    logic [15:0] target_window;
    logic [15:0] timeout_ms;
    logic [15:0] lag_max;
    logic        halt_on_lag;
  } psd_cfg_s;

  typedef struct packed {
    logic up_done;
    logic cruise_done;
    logic setpoint_reached;
    logic stopped;
    logic fault;
    logic reversal;
    logic dir_pos;
  } psd_motion_s;

endpackage

/* hw/psd_pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module psd_pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;
  wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);
  wire  [W-1:0] lvl_next = (agree & s2_reg) | (~agree & lvl_reg);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg  <= i_pin;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;

endmodule // psd_pin_sync
`default_nettype wire

/* hw/psd_positioning.sv */
// Positioning state machine with diagnostic flags and state code for one channel
`timescale 1ns/1ps
`default_nettype none
module psd_positioning
  import psd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_start,
  input  wire psd_cmd_e          i_cmd,
  input  wire logic              i_change,
  input  wire logic [POS_W-1:0]  i_target_pos,
  input  wire logic [POS_W-1:0]  i_actual_pos,
  input  wire logic [15:0]       i_actual_lag,
  input  wire logic              i_halt_req,
  input  wire psd_cfg_s          i_cfg,
  input  wire psd_motion_s       i_mot,
  input  wire logic              i_cam_pin,
  input  wire logic              i_index_pin,
  input  wire logic              i_supply_pin,
  output logic [15:0]            o_state_code,
  output logic [FLAG_N-1:0]      o_status_word,
  output logic                   o_warning,
  output logic                   o_hold_loop,
  output logic                   o_calibrated,
  output logic                   o_busy
);

  localparam int unsigned DIV_W = $clog2(TICK_CYCLES);

  function automatic logic [15:0] code_of(input psd_state_e s);
    logic [15:0] c;
    c = SC_UNDEF;
    unique case (s)
      ST_INIT:    c = SC_INIT;
      ST_IDLE:    c = SC_IDLE;
      ST_EVAL:    c = SC_EVAL;
      ST_UP:      c = SC_UP;
      ST_CRUISE:  c = SC_CRUISE;
      ST_DOWN:    c = SC_DOWN;
      ST_PRE:     c = SC_PRE;
      ST_TGT:     c = SC_TGT;
      ST_END:     c = SC_END;
      ST_RESTART: c = SC_RESTART;
      ST_WARN:    c = SC_WARN;
      ST_ERR:     c = SC_ERR;
      ST_EMERGENCY_HALT_STATE:    c = SC_EMERGENCY_HALT_STATE;
      ST_STOP:    c = SC_STOP;
      ST_HB:      c = SC_HB;
      ST_HSS:     c = SC_HSS;
      ST_HOS:     c = SC_HOS;
      ST_HSI:     c = SC_HSI;
      ST_HES:     c = SC_HES;
      ST_HD:      c = SC_HD;
      ST_CAL:     c = SC_CAL;
      ST_NOCAL:   c = SC_NOCAL;
      ST_UNDEF:   c = SC_UNDEF;
      default:    c = SC_UNDEF;
    endcase
    return c;
  endfunction

  function automatic logic [POS_W-1:0] abs_diff(input logic [POS_W-1:0] a,
                                                input logic [POS_W-1:0] b);
    return ($signed(a) > $signed(b)) ? a - b : b - a;
  endfunction

  psd_state_e          state_reg, state_next, ret_reg, ret_next;
  logic [DIV_W-1:0]    div_reg;
  logic                tick_reg;
  logic                start_pend_reg, change_pend_reg, rev_watch_reg, dir_reg;
  psd_cmd_e            cmd_reg;
  logic [POS_W-1:0]    target_reg, chg_tgt_reg;
  logic [TMO_W-1:0]    tmo_reg;
  logic [FLAG_N-1:0]   flags_reg, flag_set, flag_clr;
  logic                calib_reg;
  logic [15:0]         code_reg;
  logic                warn_reg, hold_reg, busy_reg;
  logic                cam_lvl, index_lvl, supply_lvl;

  psd_pin_sync #(.W(3)) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   ({i_cam_pin, i_index_pin, i_supply_pin}),
    .o_level ({cam_lvl, index_lvl, supply_lvl})
  );

  // Tick divider; the machine only moves on this strobe
  wire div_wrap = (div_reg == DIV_W'(TICK_CYCLES - 1));
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_wrap ? '0 : div_reg + 1'b1;
      tick_reg <= div_wrap;
    end
  end

  wire in_travel = (state_reg == ST_EVAL) || (state_reg == ST_UP) || (state_reg == ST_CRUISE)
                || (state_reg == ST_DOWN) || (state_reg == ST_PRE) || (state_reg == ST_RESTART)
                || (state_reg == ST_WARN);
  wire in_homing = (state_reg == ST_HB) || (state_reg == ST_HSS) || (state_reg == ST_HOS)
                || (state_reg == ST_HSI) || (state_reg == ST_HES);
  wire running   = in_travel || in_homing;
  wire ramping   = (state_reg == ST_UP) || (state_reg == ST_CRUISE) || (state_reg == ST_DOWN);
  wire lag_hit   = (i_cfg.lag_max != 16'h0000) && (i_actual_lag > i_cfg.lag_max);
  wire in_window = abs_diff(i_actual_pos, target_reg) <= POS_W'(i_cfg.target_window);
  wire [TMO_W-1:0] tmo_lim = TMO_W'(i_cfg.timeout_ms) * TMO_W'(TICKS_PER_MS);
  wire tmo_hit   = (tmo_reg >= tmo_lim);
  wire halt_now  = running && (i_halt_req || (lag_hit && i_cfg.halt_on_lag));
  wire fault_now = running && i_mot.fault;
  wire past_tgt  = dir_reg ? ($signed(i_actual_pos) > $signed(target_reg))
                           : ($signed(i_actual_pos) < $signed(target_reg));
  wire step      = tick_reg && supply_lvl;

  // Next state, evaluated once per tick
  always_comb begin
    state_next = state_reg;
    ret_next   = ret_reg;
    if (tick_reg && !supply_lvl) begin
      state_next = ST_UNDEF;
    end else if (step && halt_now) begin
      state_next = ST_EMERGENCY_HALT_STATE;
    end else if (step && fault_now) begin
      state_next = ST_ERR;
    end else if (step && in_travel && lag_hit && state_reg != ST_WARN) begin
      state_next = ST_WARN;
      ret_next   = state_reg;
    end else if (step && ramping && change_pend_reg) begin
      state_next = ST_RESTART;
    end else if (step) begin
      unique case (state_reg)
        ST_UNDEF:   state_next = ST_INIT;
        ST_INIT:    state_next = ST_IDLE;
        ST_IDLE: begin
          if (start_pend_reg) begin
            unique case (cmd_reg)
              CMD_TRAVEL:   state_next = ST_EVAL;
              CMD_HOME:     state_next = ST_HB;
              CMD_HOME_IDX: state_next = ST_HB;
              CMD_UNCAL:    state_next = ST_NOCAL;
            endcase
          end
        end
        ST_EVAL:    state_next = ST_UP;
        ST_UP:      if (i_mot.up_done) state_next = ST_CRUISE;
        ST_CRUISE:  if (i_mot.cruise_done) state_next = ST_DOWN;
        ST_DOWN:    if (i_mot.setpoint_reached) state_next = ST_PRE;
        ST_PRE: begin
          if (in_window) begin
            state_next = ST_TGT;
          end else if (tmo_hit) begin
            state_next = ST_WARN;
            ret_next   = ST_END;
          end
        end
        ST_TGT:     state_next = ST_END;
        ST_END:     state_next = ST_INIT;
        ST_RESTART: state_next = ST_UP;
        ST_WARN:    state_next = ret_reg;
        ST_ERR:     state_next = ST_INIT;
        ST_EMERGENCY_HALT_STATE:    if (i_mot.stopped) state_next = ST_STOP;
        ST_STOP:    if (!i_halt_req) state_next = ST_INIT;
        ST_HB:      state_next = ST_HSS;
        ST_HSS:     if (cam_lvl) state_next = ST_HOS;
        ST_HOS:     state_next = (cmd_reg == CMD_HOME_IDX) ? ST_HSI : ST_HES;
        ST_HSI:     if (index_lvl) state_next = ST_HD;
        ST_HES:     if (!cam_lvl) state_next = ST_HD;
        ST_HD:      state_next = ST_CAL;
        ST_CAL:     state_next = ST_INIT;
        ST_NOCAL:   state_next = ST_INIT;
      endcase
    end
  end

  // Flag events; a set beats a clear landing in the same cycle
  always_comb begin
    flag_set = FLAGS_RST;
    flag_set[FB_ABORT]   = step && (halt_now || fault_now);
    flag_set[FB_EHALT]   = step && halt_now;
    flag_set[FB_LAG]     = step && in_travel && lag_hit;
    flag_set[FB_TIMEOUT] = step && (state_reg == ST_PRE) && !in_window && tmo_hit;
    flag_set[FB_OVERRUN] = step && rev_watch_reg && past_tgt;
    flag_set[FB_REJECT]  = step && change_pend_reg && !ramping;
    flag_clr = {FLAG_N{step && (state_reg == ST_IDLE) && start_pend_reg}};
  end

  // Starts outside idle are dropped so they cannot disturb a running command
  wire take_start  = i_start && (state_reg == ST_IDLE);
  // A change moves the target only once taken; a rejected one leaves it alone
  wire take_change = (state_next == ST_RESTART) && (state_reg != ST_RESTART);

  // Host strobes may come at any clock; hold them until the next tick
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      start_pend_reg  <= 1'b0;
      change_pend_reg <= 1'b0;
      cmd_reg         <= CMD_TRAVEL;
      target_reg      <= '0;
      chg_tgt_reg     <= '0;
    end else begin
      start_pend_reg  <= take_start || (start_pend_reg && !step);
      change_pend_reg <= i_change || (change_pend_reg && !step);
      if (take_start) cmd_reg <= i_cmd;
      if (take_start) target_reg <= i_target_pos;
      else if (take_change) target_reg <= chg_tgt_reg;
      if (i_change) chg_tgt_reg <= i_target_pos;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_INIT;
      ret_reg   <= ST_INIT;
      flags_reg <= FLAGS_RST;
      tmo_reg   <= '0;
      calib_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ret_reg   <= ret_next;
      flags_reg <= flag_set | (flags_reg & ~flag_clr);
      if (state_reg != ST_PRE) tmo_reg <= '0;
      else if (step && !tmo_hit) tmo_reg <= tmo_reg + 1'b1;
      if (step && state_reg == ST_HD) calib_reg <= 1'b1;
      else if (step && state_reg == ST_NOCAL) calib_reg <= 1'b0;
    end
  end

  // Reversal watch armed when a late change turns the motor round
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rev_watch_reg <= 1'b0;
      dir_reg       <= 1'b0;
    end else if (step && state_reg == ST_RESTART && i_mot.reversal) begin
      rev_watch_reg <= 1'b1;
      dir_reg       <= i_mot.dir_pos;
    end else if (state_reg == ST_END || state_reg == ST_INIT) begin
      rev_watch_reg <= 1'b0;
    end
  end

  // Registered outputs; code lags the state by one clock, far below a tick
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      code_reg <= SC_INIT;
      warn_reg <= 1'b0;
      hold_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      code_reg <= code_of(state_reg);
      warn_reg <= flags_reg[FB_REJECT] || flags_reg[FB_ABORT] || flags_reg[FB_OVERRUN]
               || flags_reg[FB_LAG];
      hold_reg <= (state_reg == ST_PRE) || (state_reg == ST_TGT);
      busy_reg <= running;
    end
  end

  assign o_state_code  = code_reg;
  assign o_status_word = flags_reg;
  assign o_warning     = warn_reg;
  assign o_hold_loop   = hold_reg;
  assign o_calibrated  = calib_reg;
  assign o_busy        = busy_reg;

  sequence s_code_follows;
    1'b1 ##1 (o_state_code == code_of($past(state_reg)));
  endsequence

  property p_code;
    @(posedge i_clk) disable iff (i_rst) 1'b1 |-> s_code_follows;
  endproperty
  a_code: assert property (p_code) else $error("state code stale");

  property p_idle;
    @(posedge i_clk) disable iff (i_rst) state_reg == ST_IDLE |=> o_state_code == SC_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle code wrong");

  property p_lag_off;
    @(posedge i_clk) disable iff (i_rst)
      (i_cfg.lag_max == 16'h0000 && !flags_reg[FB_LAG] && !flag_clr[FB_LAG])
      |=> !flags_reg[FB_LAG];
  endproperty
  a_lag_off: assert property (p_lag_off) else $error("lag flag with zero limit");

  property p_lag_warn;
    @(posedge i_clk) disable iff (i_rst)
      (step && in_travel && lag_hit) |=> flags_reg[FB_LAG] ##1 o_warning;
  endproperty
  a_lag_warn: assert property (p_lag_warn) else $error("lag warning missing");

  property p_halt;
    @(posedge i_clk) disable iff (i_rst)
      (step && halt_now) |=> (state_reg == ST_EMERGENCY_HALT_STATE) && flags_reg[FB_EHALT]
                             && flags_reg[FB_ABORT] ##1 (o_state_code == SC_EMERGENCY_HALT_STATE);
  endproperty
  a_halt: assert property (p_halt) else $error("halt not taken");

  property p_abort;
    @(posedge i_clk) disable iff (i_rst) (step && fault_now && !halt_now)
      |=> (state_reg == ST_ERR) && flags_reg[FB_ABORT];
  endproperty
  a_abort: assert property (p_abort) else $error("fault abort missing");

  property p_undef;
    @(posedge i_clk) disable iff (i_rst)
      (tick_reg && !supply_lvl) |=> (state_reg == ST_UNDEF) ##1 (o_state_code == SC_UNDEF);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code missing");

  property p_pre_hold;
    @(posedge i_clk) disable iff (i_rst) (state_reg == ST_PRE) |=> o_hold_loop;
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("loop not held");

  property p_target;
    @(posedge i_clk) disable iff (i_rst)
      (state_reg == ST_TGT && $past(state_reg) == ST_PRE) |-> $past(in_window);
  endproperty
  a_target: assert property (p_target) else $error("target without window");

  property p_tick;
    @(posedge i_clk) disable iff (i_rst) $changed(state_reg) |-> $past(tick_reg);
  endproperty
  a_tick: assert property (p_tick) else $error("state moved off tick");

endmodule // psd_positioning
`default_nettype wire

/* bench/psd_motion_model.sv */
// Motion core and pin model that answers the state code of the positioning block
`timescale 1ns/1ps
`default_nettype none
module psd_motion_model
  import psd_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [15:0]      i_code,
  input  wire logic [POS_W-1:0] i_tgt,
  input  wire logic [7:0]       i_dly,
  input  wire logic             i_miss,
  input  wire logic             i_over,
  input  wire logic             i_fault,
  output var  psd_motion_s      o_mot,
  output logic [POS_W-1:0]      o_act,
  output logic                  o_cam,
  output logic                  o_index
);
  logic [15:0] seen_reg;
  logic [7:0]  dwell_reg;
  logic        rdy;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seen_reg  <= SC_INIT;
      dwell_reg <= 8'h00;
    end else begin
      seen_reg  <= i_code;
      dwell_reg <= (i_code != seen_reg) ? 8'h00 :
                   ((dwell_reg == 8'hFF) ? dwell_reg : dwell_reg + 8'h01);
    end
  end

  // Never answers in the first cycle of a state, so no zero-time shortcut
  assign rdy = (i_code == seen_reg) && (dwell_reg >= i_dly);

  always_comb begin
    o_mot                  = '0;
    o_mot.up_done          = (i_code == SC_UP) && rdy;
    o_mot.cruise_done      = (i_code == SC_CRUISE) && rdy;
    o_mot.setpoint_reached = (i_code == SC_DOWN) && rdy;
    o_mot.stopped          = (i_code == SC_EMERGENCY_HALT_STATE) && rdy;
    o_mot.reversal         = i_over;
    o_mot.fault            = i_fault;
    o_mot.dir_pos          = 1'b1;
  end

  // Overshoot stays inside the window; a miss lands far outside it
  assign o_act   = i_tgt + (i_miss ? 32'h00010000 : (i_over ? 32'h00000005 : 32'h00000000));
  assign o_cam   = ((i_code == SC_HSS) && rdy) || (i_code == SC_HOS);
  assign o_index = (i_code == SC_HSI) && rdy;
endmodule // psd_motion_model
`default_nettype wire

/* bench/positioning_state_diag_test.sv */
// Self-checking bench for the positioning state machine and its flags
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module positioning_state_diag_test
  import psd_pkg::*;
;
  localparam int TK = 8;
  logic clk, rst, start, change, halt, miss, over, supply, cam, idx, fault;
  logic warn, hold, cal, busy;
  psd_cmd_e          cmd;
  psd_cfg_s          cfg;
  psd_motion_s       mot;
  logic [POS_W-1:0]  tgt, act;
  logic [15:0]       lag, code, prev, ex;
  logic [FLAG_N-1:0] sw;
  logic [7:0]        dly;
  logic [15:0]       expq[$];
  int n_fail, compares, seed, ncyc, lastc;

  psd_positioning #(.TICK_CYCLES(TK)) uut (
    .i_clk(clk), .i_rst(rst), .i_start(start), .i_cmd(cmd), .i_change(change),
    .i_target_pos(tgt), .i_actual_pos(act), .i_actual_lag(lag), .i_halt_req(halt),
    .i_cfg(cfg), .i_mot(mot), .i_cam_pin(cam), .i_index_pin(idx), .i_supply_pin(supply),
    .o_state_code(code), .o_status_word(sw), .o_warning(warn), .o_hold_loop(hold),
    .o_calibrated(cal), .o_busy(busy));

  psd_motion_model mdl (
    .i_clk(clk), .i_rst(rst), .i_code(code), .i_tgt(tgt), .i_dly(dly), .i_miss(miss),
    .i_over(over), .i_fault(fault), .o_mot(mot), .o_act(act), .o_cam(cam), .o_index(idx));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Every code change must match the oldest note; each after the first must land a whole number of ticks after the last
  always @(negedge clk) begin
    ncyc++;
    if (rst) begin
      prev  = SC_INIT;
      lastc = -1;
    end else if (code !== prev) begin
      prev = code;
      ex   = (expq.size() != 0) ? expq.pop_front() : ~code;
      `CHK("state_code", ex, code)
      if (lastc >= 0) `CHK("tick_phase", 0, (ncyc - lastc) % TK)
      lastc = ncyc;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic go(input psd_cmd_e c);
    tgt   = $random(seed);
    cmd   = c;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
  endtask

  task automatic wcode(input logic [15:0] c);
    int i;
    for (i = 0; i < 1000 && code !== c; i++) cyc(1);
    `CHK("wait_code", c, code)
  endtask

  task automatic drain;
    int i;
    for (i = 0; i < 3000 && expq.size() != 0; i++) cyc(1);
    if (expq.size() != 0) begin
      n_fail++;
      $display("[ERR] drain exp %h got %h", expq[0], code);
      expq.delete();
    end
    cyc(3);
  endtask

  task automatic st(input logic [FLAG_N-1:0] f, input logic w);
    `CHK("status_word", f, sw)
    `CHK("warning", w, warn)
  endtask

  task automatic close_out;
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    close_out;
  end

  initial begin
    seed = 66368;
    n_fail = 0;
    compares = 0;
    ncyc = 0;
    rst = 1'b1; start = 1'b0; change = 1'b0; halt = 1'b0; miss = 1'b0; over = 1'b0;
    supply = 1'b1; cmd = CMD_TRAVEL; tgt = '0; lag = '0; dly = 8'h00;
    fault = 1'b0;
    cfg = '{16'h000A, 16'h0001, 16'h0000, 1'b0};
    cyc(20);
    `CHK("reset_code", SC_INIT, code)
    rst = 1'b0;
    expq = {SC_IDLE};
    drain;
    // Plain travel with a large lag but monitoring switched off
    lag = 16'($random(seed));
    expq = {SC_EVAL, SC_UP, SC_CRUISE, SC_DOWN, SC_PRE, SC_TGT, SC_END, SC_INIT, SC_IDLE};
    go(CMD_TRAVEL);
    wcode(SC_PRE);
    `CHK("hold_loop", 1'b1, hold)
    `CHK("busy", 1'b1, busy)
    drain;
    st(6'h00, 1'b0);
    `CHK("busy_end", 1'b0, busy)
    // A change while idle cannot be carried out
    change = 1'b1;
    cyc(1);
    change = 1'b0;
    cyc(3 * TK);
    st(6'h01, 1'b1);
    // Window missed: timeout after four ticks per millisecond
    miss = 1'b1;
    expq = {SC_EVAL, SC_UP, SC_CRUISE, SC_DOWN, SC_PRE, SC_WARN, SC_END, SC_INIT, SC_IDLE};
    go(CMD_TRAVEL);
    drain;
    st(6'h08, 1'b0);
    miss = 1'b0;
    // Lag one above a random limit during ramp-up
    cfg.lag_max = 16'h0001 + 16'($random(seed) & 32'h000003FF);
    lag = 16'h0000;
    dly = 8'd20;
    expq = {SC_EVAL, SC_UP, SC_WARN, SC_UP, SC_CRUISE, SC_DOWN, SC_PRE, SC_TGT, SC_END,
            SC_INIT, SC_IDLE};
    go(CMD_TRAVEL);
    wcode(SC_UP);
    lag = cfg.lag_max + 16'h0001;
    wcode(SC_WARN);
    lag = cfg.lag_max;
    drain;
    st(6'h10, 1'b1);
    // Host halt in mid-ramp
    dly = 8'd60;
    expq = {SC_EVAL, SC_UP, SC_EMERGENCY_HALT_STATE, SC_STOP, SC_INIT, SC_IDLE};
    go(CMD_TRAVEL);
    wcode(SC_UP);
    halt = 1'b1;
    wcode(SC_STOP);
    halt = 1'b0;
    drain;
    st(6'h22, 1'b1);
    // Motion fault in mid-ramp ends the travel early
    expq = {SC_EVAL, SC_UP, SC_ERR, SC_INIT, SC_IDLE};
    go(CMD_TRAVEL);
    wcode(SC_UP);
    fault = 1'b1;
    wcode(SC_ERR);
    fault = 1'b0;
    drain;
    st(6'h02, 1'b1);
    // Lag error with automatic emergency halt
    cfg.halt_on_lag = 1'b1;
    expq = {SC_EVAL, SC_UP, SC_EMERGENCY_HALT_STATE, SC_STOP, SC_INIT, SC_IDLE};
    go(CMD_TRAVEL);
    wcode(SC_UP);
    lag = cfg.lag_max + 16'h0001;
    wcode(SC_EMERGENCY_HALT_STATE);
    lag = cfg.lag_max;
    cfg.halt_on_lag = 1'b0;
    drain;
    st(6'h32, 1'b1);
    // Late target change with reversal that overshoots
    dly = 8'd20;
    over = 1'b1;
    expq = {SC_EVAL, SC_UP, SC_CRUISE, SC_RESTART, SC_UP, SC_CRUISE, SC_DOWN, SC_PRE,
            SC_TGT, SC_END, SC_INIT, SC_IDLE};
    go(CMD_TRAVEL);
    wcode(SC_CRUISE);
    tgt = $random(seed);
    change = 1'b1;
    cyc(1);
    change = 1'b0;
    drain;
    st(6'h04, 1'b1);
    over = 1'b0;
    // Homing with and without the index pulse, then back to uncalibrated
    for (int k = 0; k < 2; k++) begin
      expq = {SC_HB, SC_HSS, SC_HOS, (k != 0) ? SC_HSI : SC_HES, SC_HD, SC_CAL, SC_INIT,
              SC_IDLE};
      if (k != 0) go(CMD_HOME_IDX);
      else go(CMD_HOME);
      drain;
      `CHK("calibrated", 1'b1, cal)
    end
    expq = {SC_NOCAL, SC_INIT, SC_IDLE};
    go(CMD_UNCAL);
    drain;
    `CHK("uncalibrated", 1'b0, cal)
    // Driver supply lost while idle
    expq = {SC_UNDEF, SC_INIT, SC_IDLE};
    supply = 1'b0;
    wcode(SC_UNDEF);
    supply = 1'b1;
    drain;
    close_out;
  end
endmodule // positioning_state_diag_test
`default_nettype wire
